/* File: channel_nco_tuning_word_load.sv */
// Per-channel oscillator settings, tuning-word holding storage and load logic.
// Assumes the register port and page index are on sys_clk_in; the system
// reference arrives from a pin and is synchronised here.
`timescale 1ns/1ps
// Summary of operation
// - With the sideband select bit set, the channel takes the lower sideband, a spectral flip.
// - Datapath config bit 0 set feeds a dc level into the oscillator input; clear disables it.
// - In test-tone mode the dc level is the test amplitude setting from its two registers.
// - With the sysref-load bit set, the next sysref rising edge loads the word and resets the oscillator.
// - The read-only acknowledge bit reads 1 once the word and phase offset are loaded, 0 before.
// - Of request-bit writes, only a zero-to-one change loads the tuning word.
// - Without modulus mode the output frequency is rate times word over two to the 48.
// - All controls are per channel, and accesses go to the channel the page field selects.
// - The word is built from byte registers in ascending order at consecutive addresses.
// - With modulus mode the frequency is rate times word plus delta over modulus, over two to the 48.
module channel_nco_tuning_word_load
   import nco_tuning_pkg::*;
(
   input  wire logic                        sys_clk_in,
   input  wire logic                        rst_b_in,
   input  wire reg_req_t                    reg_req_in,
   input  wire logic                        sysref_in,
   input  wire logic [NUM_CH-1:0][23:0]     tuning_word_upper_in,
   input  wire logic [NUM_CH-1:0][15:0]     phase_offset_in,
   input  wire logic [NUM_CH-1:0][15:0]     test_tone_level_in,
   input  wire logic [NUM_CH-1:0]           channel_modulus_mode_enable_in,
   input  wire logic [NUM_CH-1:0][47:0]     channel_accumulator_delta_in,
   input  wire logic [NUM_CH-1:0][47:0]     channel_accumulator_modulus_in,
   output logic      [7:0]                  reg_rdata_out,
   output logic      [NUM_CH-1:0][47:0]     active_tuning_word_out,
   output logic      [NUM_CH-1:0]           oscillator_reset_out,
   output logic      [NUM_CH-1:0][15:0]     oscillator_phase_out,
   output logic      [NUM_CH-1:0]           sideband_lower_out,
   output logic      [NUM_CH-1:0]           test_tone_enable_out,
   output logic      [NUM_CH-1:0][15:0]     test_tone_dc_out
);
   state_t st;
   state_t next_st;
   logic   sysref_rise;

   // Only the second and third stages are read; the first is metastability guard
   assign sysref_rise = st.sysref_sync[1] & ~st.sysref_sync[2];

   always_comb begin
      logic           sel;
      logic           wr_sel;
      logic           load;
      logic [47:0]    frac_sum;
      logic [47:0]    carry;
      logic [7:0]     rd;
      next_st = st;
      sel = 1'b0;
      wr_sel = 1'b0;
      load = 1'b0;
      frac_sum = '0;
      carry = '0;
      rd = RESET_BYTE;
      next_st.sysref_sync = {st.sysref_sync[1:0], sysref_in};
      for (int c = 0; c < NUM_CH; c++) begin
         sel = (reg_req_in.page == c[PAGE_W-1:0]);
         wr_sel = sel & reg_req_in.wr;
         load = 1'b0;
         next_st.ch[c].osc_reset = 1'b0;
         if (wr_sel) begin
            case (reg_req_in.addr)
               ADDR_DP_CFG: begin
                  next_st.ch[c].sideband = reg_req_in.wdata[BIT_SIDEBAND];
                  next_st.ch[c].tone_en  = reg_req_in.wdata[BIT_TEST_TONE];
               end
               ADDR_UPDATE: begin
                  next_st.ch[c].load_req    = reg_req_in.wdata[BIT_LOAD_REQ];
                  next_st.ch[c].load_sysref = reg_req_in.wdata[BIT_LOAD_SYSREF];
                  next_st.ch[c].sysref_armed = reg_req_in.wdata[BIT_LOAD_SYSREF];
                  // Steady one does not reload; only the rising change does
                  load = reg_req_in.wdata[BIT_LOAD_REQ] & ~st.ch[c].load_req;
               end
               // New pending bytes make the previous acknowledge stale
               ADDR_FTW_BYTE0: begin
                  next_st.ch[c].ftw_hold[7:0] = reg_req_in.wdata;
                  next_st.ch[c].load_ack = 1'b0;
               end
               ADDR_FTW_BYTE1: begin
                  next_st.ch[c].ftw_hold[15:8] = reg_req_in.wdata;
                  next_st.ch[c].load_ack = 1'b0;
               end
               ADDR_FTW_BYTE2: begin
                  next_st.ch[c].ftw_hold[23:16] = reg_req_in.wdata;
                  next_st.ch[c].load_ack = 1'b0;
               end
               default: ;
            endcase
         end
         if (st.ch[c].sysref_armed && sysref_rise) begin
            load = 1'b1;
            next_st.ch[c].sysref_armed = 1'b0;
         end
         // Accumulator: integer word plus fractional delta over modulus
         frac_sum = st.ch[c].frac + channel_accumulator_delta_in[c];
         carry = '0;
         if (channel_modulus_mode_enable_in[c]) begin
            if (frac_sum >= channel_accumulator_modulus_in[c]) begin
               frac_sum = frac_sum - channel_accumulator_modulus_in[c];
               carry = 48'h000000000001;
            end
            next_st.ch[c].frac = frac_sum;
         end else begin
            next_st.ch[c].frac = '0;
         end
         next_st.ch[c].acc = st.ch[c].acc + st.ch[c].ftw_active + carry;
         // Load wins over a byte write in the same cycle, so ack is set
         if (load) begin
            next_st.ch[c].ftw_active = {tuning_word_upper_in[c], st.ch[c].ftw_hold};
            next_st.ch[c].phase_off  = phase_offset_in[c];
            next_st.ch[c].acc        = '0;
            next_st.ch[c].frac       = '0;
            next_st.ch[c].osc_reset  = 1'b1;
            next_st.ch[c].load_ack   = 1'b1;
         end
         // Lower sideband taken by running the phase backwards
         if (st.ch[c].sideband) begin
            next_st.ch[c].phase = 16'h0000 - (st.ch[c].acc[47:32] + st.ch[c].phase_off);
         end else begin
            next_st.ch[c].phase = st.ch[c].acc[47:32] + st.ch[c].phase_off;
         end
         next_st.ch[c].tone_dc = st.ch[c].tone_en ? test_tone_level_in[c] : 16'h0000;
         if (sel) begin
            case (reg_req_in.addr)
               ADDR_DP_CFG:    rd = {6'h00, st.ch[c].sideband, st.ch[c].tone_en};
               ADDR_UPDATE:    rd = {5'h00, st.ch[c].load_sysref, st.ch[c].load_ack,
                                     st.ch[c].load_req};
               ADDR_FTW_BYTE0: rd = st.ch[c].ftw_hold[7:0];
               ADDR_FTW_BYTE1: rd = st.ch[c].ftw_hold[15:8];
               ADDR_FTW_BYTE2: rd = st.ch[c].ftw_hold[23:16];
               default:        rd = RESET_BYTE;
            endcase
         end
      end
      next_st.rdata = rd;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_out = st.rdata;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_out
      assign active_tuning_word_out[g] = st.ch[g].ftw_active;
      assign oscillator_reset_out[g]   = st.ch[g].osc_reset;
      assign oscillator_phase_out[g]   = st.ch[g].phase;
      assign sideband_lower_out[g]     = st.ch[g].sideband;
      assign test_tone_enable_out[g]   = st.ch[g].tone_en;
      assign test_tone_dc_out[g]       = st.ch[g].tone_dc;
   end
endmodule : channel_nco_tuning_word_load

/* File: channel_nco_tuning_word_load_tb_top.sv */
// Testbench for the tuning-word load block: register tasks and directed loads.
// Assumes the checker file is compiled alongside; modulus and phase inputs tied.
`timescale 1ns/1ps
module channel_nco_tuning_word_load_tb_top;
   import nco_tuning_pkg::*;
   logic                    sys_clk_in = 1'b0, rst_b_in = 1'b0, sysref = 1'b0;
   reg_req_t                rq = '0;
   logic [NUM_CH-1:0][23:0] upper = '0;
   logic [NUM_CH-1:0][15:0] level = {16'h1234, 16'h0000, 16'h00a5};
   logic [NUM_CH-1:0][15:0] dc, phase;
   logic [NUM_CH-1:0]       orst;
   logic [NUM_CH-1:0][47:0] word;
   logic [NUM_CH-1:0]       side, tone;
   logic [7:0]              rdata;
   int                      num_errors = 0, cmp_count = 0, cycles = 0;
   channel_nco_tuning_word_load dut_u (.sys_clk_in, .rst_b_in, .reg_req_in(rq), .sysref_in(sysref),
      .tuning_word_upper_in(upper), .phase_offset_in('0), .test_tone_level_in(level),
      .channel_modulus_mode_enable_in('0), .channel_accumulator_delta_in('0),
      .channel_accumulator_modulus_in('0), .reg_rdata_out(rdata), .active_tuning_word_out(word),
      .oscillator_reset_out(orst), .oscillator_phase_out(phase), .sideband_lower_out(side),
      .test_tone_enable_out(tone), .test_tone_dc_out(dc));
   initial forever #20 sys_clk_in = ~sys_clk_in;
   task automatic stop_test();
      $display("Mismatches %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Strobe drops on the sampling edge so a following write can rise at the next fall
   task automatic wr(input logic [1:0] pg, input logic [11:0] a, input logic [7:0] d);
      rq = '{1'b1, a, d, pg};
      @(posedge sys_clk_in);
      rq.wr <= 1'b0;
      @(negedge sys_clk_in);
   endtask : wr
   task automatic rd(input logic [1:0] pg, input logic [11:0] a, input logic [7:0] e);
      rq = '{1'b0, a, 8'h00, pg};
      repeat (2) @(negedge sys_clk_in);
      chk(48'(rdata), 48'(e));
   endtask : rd
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 1000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      for (int a = 0; a < 5; a++) rd(2'h0, ADDR_DP_CFG + 12'(a), RESET_BYTE);
      upper[0] = 24'habcdef;
      wr(2'h0, ADDR_FTW_BYTE0, 8'h11);
      wr(2'h0, ADDR_FTW_BYTE1, 8'h22);
      wr(2'h0, ADDR_FTW_BYTE2, 8'h33);
      chk(word[0], 48'h0);
      rd(2'h0, ADDR_FTW_BYTE1, 8'h22);
      rd(2'h0, ADDR_UPDATE, 8'h00);
      wr(2'h0, ADDR_UPDATE, 8'h01);
      chk(word[0], 48'habcdef_332211);
      rd(2'h0, ADDR_UPDATE, 8'h03);
      wr(2'h0, ADDR_FTW_BYTE0, 8'h44);
      rd(2'h0, ADDR_UPDATE, 8'h01);
      wr(2'h0, ADDR_UPDATE, 8'h01);
      wr(2'h0, ADDR_UPDATE, 8'h01);
      chk(word[0], 48'habcdef_332211);
      wr(2'h0, ADDR_UPDATE, 8'h00);
      wr(2'h0, ADDR_UPDATE, 8'h01);
      chk(word[0], 48'habcdef_332244);
      wr(2'h0, ADDR_FTW_BYTE2, 8'h55);
      wr(2'h0, ADDR_UPDATE, 8'h04);
      chk(word[0], 48'habcdef_332244);
      sysref = 1'b1;
      repeat (6) @(negedge sys_clk_in);
      chk(word[0], 48'habcdef_552244);
      rd(2'h0, ADDR_UPDATE, 8'h06);
      upper[1] = 24'h010000;
      wr(2'h1, ADDR_UPDATE, 8'h01);
      chk(48'(orst[1]), 48'h1);
      repeat (4) @(negedge sys_clk_in);
      chk(48'(orst[1]), 48'h0);
      chk(48'(phase[1]), 48'h0300);
      wr(2'h0, ADDR_DP_CFG, 8'h02);
      wr(2'h0, ADDR_DP_CFG, 8'h01);
      wr(2'h2, ADDR_DP_CFG, 8'h03);
      wr(2'h3, ADDR_DP_CFG, 8'h03);
      @(negedge sys_clk_in);
      chk(48'({side, tone}), 48'h25);
      chk(48'({dc[2], dc[0]}), 48'h1234_00a5);
      rd(2'h2, ADDR_DP_CFG, 8'h03);
      rd(2'h3, ADDR_DP_CFG, 8'h00);
      rd(2'h2, 12'h1ff, 8'h00);
      stop_test();
   end
endmodule : channel_nco_tuning_word_load_tb_top

/* File: nco_tuning_asserts.sv */
// Checker for the tuning-word load block, channel 0 and the register port.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module nco_tuning_asserts
   import nco_tuning_pkg::*;
(
   input wire logic                    sys_clk_in,
   input wire logic                    rst_b_in,
   input wire reg_req_t                reg_req_in,
   input wire logic [NUM_CH-1:0][15:0] test_tone_level_in,
   input wire logic [7:0]              reg_rdata_out,
   input wire logic [NUM_CH-1:0][47:0] active_tuning_word_out,
   input wire logic [NUM_CH-1:0]       oscillator_reset_out,
   input wire logic [NUM_CH-1:0]       sideband_lower_out,
   input wire logic [NUM_CH-1:0]       test_tone_enable_out,
   input wire logic [NUM_CH-1:0][15:0] test_tone_dc_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_cfg0;
      reg_req_in.wr && reg_req_in.addr == ADDR_DP_CFG && reg_req_in.page == 2'h0;
   endsequence
   sequence s_req0;
      reg_req_in.wr && reg_req_in.addr == ADDR_UPDATE && reg_req_in.page == 2'h0 &&
         reg_req_in.wdata[BIT_LOAD_REQ];
   endsequence
   property p_side; s_cfg0 |=> sideband_lower_out[0] == $past(reg_req_in.wdata[1]); endproperty
   a_side: assert property (p_side) else $error("sideband not taken");
   property p_tone; s_cfg0 |=> test_tone_enable_out[0] == $past(reg_req_in.wdata[0]); endproperty
   a_tone: assert property (p_tone) else $error("tone enable not taken");
   property p_dc; $stable(test_tone_enable_out[0]) && $stable(test_tone_level_in[0]) |->
      test_tone_dc_out[0] == (test_tone_enable_out[0] ? test_tone_level_in[0] : 16'h0000); endproperty
   a_dc: assert property (p_dc) else $error("dc level wrong");
   property p_word; $changed(active_tuning_word_out[0]) |-> oscillator_reset_out[0]; endproperty
   a_word: assert property (p_word) else $error("word moved without load");
   property p_ack; oscillator_reset_out[0] && reg_req_in.addr == ADDR_UPDATE &&
      reg_req_in.page == 2'h0 |=> reg_rdata_out[BIT_LOAD_ACK]; endproperty
   a_ack: assert property (p_ack) else $error("ack not set after load");
   // A held request bit must not reload the running word
   property p_edge; s_req0 ##1 s_req0 |=> !oscillator_reset_out[0]; endproperty
   a_edge: assert property (p_edge) else $error("load on steady request");
   property p_pg3; reg_req_in.page == 2'h3 |=> reg_rdata_out == 8'h00; endproperty
   a_pg3: assert property (p_pg3) else $error("page 3 read not zero");
   property p_steer; reg_req_in.wr && reg_req_in.page != 2'h0 |=>
      $stable(sideband_lower_out[0]) && $stable(test_tone_enable_out[0]); endproperty
   a_steer: assert property (p_steer) else $error("write leaked into channel 0");
endmodule : nco_tuning_asserts
bind channel_nco_tuning_word_load nco_tuning_asserts chk_u (.*);

/* File: nco_tuning_pkg.sv */
// Constants and carrier types for the channel oscillator tuning-word load block.
// Assumes an 8-bit register port with a 12-bit byte address, already decoded
// from the serial control port, and a channel page index from the paging logic.
package nco_tuning_pkg;
   localparam int          NUM_CH          = 3;
   localparam int          PAGE_W          = 2;
   localparam int          ADDR_W          = 12;
   localparam int          FTW_W           = 48;
   localparam int          HOLD_W          = 24;
   localparam int          PHASE_W         = 16;
   localparam int          LEVEL_W         = 16;
   localparam logic [11:0] ADDR_DP_CFG     = 12'h130;
   localparam logic [11:0] ADDR_UPDATE     = 12'h131;
   localparam logic [11:0] ADDR_FTW_BYTE0  = 12'h132;
   localparam logic [11:0] ADDR_FTW_BYTE1  = 12'h133;
   localparam logic [11:0] ADDR_FTW_BYTE2  = 12'h134;
   localparam int          BIT_TEST_TONE   = 0;
   localparam int          BIT_SIDEBAND    = 1;
   localparam int          BIT_LOAD_REQ    = 0;
   localparam int          BIT_LOAD_ACK    = 1;
   localparam int          BIT_LOAD_SYSREF = 2;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;

   typedef struct packed {
      logic                 sideband;
      logic                 tone_en;
      logic                 load_req;
      logic                 load_ack;
      logic                 load_sysref;
      logic                 sysref_armed;
      logic [HOLD_W-1:0]    ftw_hold;
      logic [FTW_W-1:0]     ftw_active;
      logic [PHASE_W-1:0]   phase_off;
      logic [FTW_W-1:0]     acc;
      logic [FTW_W-1:0]     frac;
      logic                 osc_reset;
      logic [PHASE_W-1:0]   phase;
      logic [LEVEL_W-1:0]   tone_dc;
   } chan_t;

   typedef struct packed {
      logic                 wr;
      logic [ADDR_W-1:0]    addr;
      logic [7:0]           wdata;
      logic [PAGE_W-1:0]    page;
   } reg_req_t;

   typedef struct packed {
      logic [2:0]           sysref_sync;
      logic [7:0]           rdata;
      chan_t [NUM_CH-1:0]   ch;
   } state_t;
endpackage : nco_tuning_pkg
